// ---- inc/sdpc_defs.vh ----
// Constants shared by the dual-port counter memory design
// What this block does
// RL1: Both ports reach any memory word at once, each with its own controls.
// RL2: Each port samples control, address and write data on the clock edge.
// RL3: Each port picks flow-through or pipelined read output by a mode bit.
// RL4: A port sampled with either chip select inactive deselects and floats.
// RL5: Selected with read_write low writes; with it high and oe low it reads.
// RL6: Output enable high floats the data pins at once, without the clock.
// RL7: Chip selects pass one stage in flow-through and two when pipelined.
// RL8: Pipelined read data comes one cycle later than flow-through data.
// RL9: Strobe low with clear high loads the external address, selects aside.
// RL10: Strobe high with advance low steps the internal address by one.
// RL11: Strobe and advance both high hold the previous internal address.
// RL12: Clear low sets the internal address to zero above all else.
// RL13: A write completes inside one clock cycle with no external pulse.
// RL14: Hosts must not collide writes, or write and read, on one address.
`ifndef SDPC_DEFS_VH
`define SDPC_DEFS_VH

// ==========================================================
// Register map, byte addresses
`define SDPC_REG_CTRL 8'h00
`define SDPC_REG_ADDR_A 8'h04
`define SDPC_REG_ADDR_B 8'h08
`define SDPC_REG_STATUS 8'h0C

// ==========================================================
// Control fields and reset value
`define SDPC_CTRL_MODE_A 0
`define SDPC_CTRL_MODE_B 1
`define SDPC_CTRL_RESET 2'h0

// ==========================================================
// Status fields
`define SDPC_STAT_SEL_A 0
`define SDPC_STAT_DRV_A 1
`define SDPC_STAT_SEL_B 2
`define SDPC_STAT_DRV_B 3

// ==========================================================
// Bus responses and counter reset value
`define SDPC_RESP_OKAY 2'h0
`define SDPC_RESP_SLVERR 2'h2
`define SDPC_ADDR_RESET 16'h0000

`endif

// ---- hw/sdpc_port.v ----
// One synchronous memory port with burst address counter
`timescale 1ns/1ns
`include "sdpc_defs.vh"

module sdpc_port #(
    parameter ADDR_W = 16,
    parameter DATA_W = 8
) (
    input wire mclk,
    input wire reset_n,
    input wire chip_select_n,
    input wire chip_select_p,
    input wire read_write,
    input wire output_enable_n,
    input wire address_strobe_n,
    input wire counter_advance_n,
    input wire counter_clear_n,
    input wire output_mode_select,
    input wire [ADDR_W-1:0] port_address,
    input wire [DATA_W-1:0] port_data_in,
    input wire [DATA_W-1:0] mem_rdata,
    output reg [DATA_W-1:0] port_data_out,
    output wire port_data_oe,
    output reg [ADDR_W-1:0] mem_addr,
    output wire mem_we,
    output wire [DATA_W-1:0] mem_wdata,
    output reg [ADDR_W-1:0] int_addr,
    output reg selected,
    output reg driving
);

    // ==========================================================
    // Address counter
    wire sel_now;
    reg [DATA_W-1:0] data_stage;
    reg read_stage;

    always @* begin
        if (!counter_clear_n) begin
            mem_addr = {ADDR_W{1'b0}}; // see RL12
        end else if (!address_strobe_n) begin
            mem_addr = port_address; // see RL9
        end else if (!counter_advance_n) begin
            mem_addr = int_addr + {{(ADDR_W-1){1'b0}}, 1'b1}; // see RL10
        end else begin
            mem_addr = int_addr; // see RL11
        end
    end

    // Counter runs whatever the chip selects say
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            int_addr <= `SDPC_ADDR_RESET;
        end else begin
            int_addr <= mem_addr; // see RL2
        end
    end

    // ==========================================================
    // Write path: the array stores at this same edge
    assign sel_now = !chip_select_n && chip_select_p; // see RL4
    assign mem_we = sel_now && !read_write; // see RL5, see RL13
    assign mem_wdata = port_data_in;

    // ==========================================================
    // Read pipeline
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            data_stage <= {DATA_W{1'b0}};
            read_stage <= 1'b0;
            port_data_out <= {DATA_W{1'b0}};
            driving <= 1'b0;
            selected <= 1'b0;
        end else begin
            selected <= sel_now; // see RL4
            data_stage <= mem_rdata;
            read_stage <= sel_now && read_write;
            if (output_mode_select) begin
                port_data_out <= data_stage; // see RL8
                driving <= read_stage; // see RL7
            end else begin
                port_data_out <= mem_rdata; // see RL3
                driving <= sel_now && read_write; // see RL7
            end
        end
    end

    // Gated without the clock so the pins float at once
    assign port_data_oe = driving && !output_enable_n; // see RL6, see RL5

endmodule // sdpc_port

// ---- hw/sdpc_top.v ----
// Dual-port counter memory with its AXI4-Lite control slave
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "sdpc_defs.vh"

module sdpc_top #(
    parameter ADDR_W = 16,
    parameter DATA_W = 8,
    parameter AXI_AW = 8
) (
    input wire mclk,
    input wire reset_n,
    input wire a_chip_select_n,
    input wire a_chip_select_p,
    input wire a_read_write,
    input wire a_output_enable_n,
    input wire a_address_strobe_n,
    input wire a_counter_advance_n,
    input wire a_counter_clear_n,
    input wire [ADDR_W-1:0] a_port_address,
    input wire [DATA_W-1:0] a_port_data_in,
    output wire [DATA_W-1:0] a_port_data_out,
    output wire a_port_data_oe,
    input wire b_chip_select_n,
    input wire b_chip_select_p,
    input wire b_read_write,
    input wire b_output_enable_n,
    input wire b_address_strobe_n,
    input wire b_counter_advance_n,
    input wire b_counter_clear_n,
    input wire [ADDR_W-1:0] b_port_address,
    input wire [DATA_W-1:0] b_port_data_in,
    output wire [DATA_W-1:0] b_port_data_out,
    output wire b_port_data_oe,
    input wire [AXI_AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AXI_AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ==========================================================
    // Shared array
    localparam DEPTH = 1 << ADDR_W;

    reg [DATA_W-1:0] mem [0:DEPTH-1];
    wire [ADDR_W-1:0] a_mem_addr;
    wire [ADDR_W-1:0] b_mem_addr;
    wire a_mem_we;
    wire b_mem_we;
    wire [DATA_W-1:0] a_mem_wdata;
    wire [DATA_W-1:0] b_mem_wdata;
    wire [ADDR_W-1:0] a_int_addr;
    wire [ADDR_W-1:0] b_int_addr;
    wire a_selected;
    wire b_selected;
    wire a_driving;
    wire b_driving;
    reg [1:0] ctrl;

    // Same-word collisions are left to the hosts; port B lands last
    always @(posedge mclk) begin
        if (a_mem_we) begin
            mem[a_mem_addr] <= a_mem_wdata; // see RL1, see RL13
        end
        if (b_mem_we) begin
            mem[b_mem_addr] <= b_mem_wdata; // see RL1, see RL14
        end
    end

    // ==========================================================
    // The two ports
    sdpc_port #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_port_a (
        .mclk(mclk),
        .reset_n(reset_n),
        .chip_select_n(a_chip_select_n),
        .chip_select_p(a_chip_select_p),
        .read_write(a_read_write),
        .output_enable_n(a_output_enable_n),
        .address_strobe_n(a_address_strobe_n),
        .counter_advance_n(a_counter_advance_n),
        .counter_clear_n(a_counter_clear_n),
        .output_mode_select(ctrl[`SDPC_CTRL_MODE_A]),
        .port_address(a_port_address),
        .port_data_in(a_port_data_in),
        .mem_rdata(mem[a_mem_addr]),
        .port_data_out(a_port_data_out),
        .port_data_oe(a_port_data_oe),
        .mem_addr(a_mem_addr),
        .mem_we(a_mem_we),
        .mem_wdata(a_mem_wdata),
        .int_addr(a_int_addr),
        .selected(a_selected),
        .driving(a_driving)
    );

    sdpc_port #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_port_b (
        .mclk(mclk),
        .reset_n(reset_n),
        .chip_select_n(b_chip_select_n),
        .chip_select_p(b_chip_select_p),
        .read_write(b_read_write),
        .output_enable_n(b_output_enable_n),
        .address_strobe_n(b_address_strobe_n),
        .counter_advance_n(b_counter_advance_n),
        .counter_clear_n(b_counter_clear_n),
        .output_mode_select(ctrl[`SDPC_CTRL_MODE_B]),
        .port_address(b_port_address),
        .port_data_in(b_port_data_in),
        .mem_rdata(mem[b_mem_addr]),
        .port_data_out(b_port_data_out),
        .port_data_oe(b_port_data_oe),
        .mem_addr(b_mem_addr),
        .mem_we(b_mem_we),
        .mem_wdata(b_mem_wdata),
        .int_addr(b_int_addr),
        .selected(b_selected),
        .driving(b_driving)
    );

    // ==========================================================
    // Register decode
    // Index 0..3 for mapped words, 4 for anything else
    function [2:0] reg_index;
        input [AXI_AW-1:0] addr;
        begin
            case (addr)
                `SDPC_REG_CTRL: reg_index = 3'h0;
                `SDPC_REG_ADDR_A: reg_index = 3'h1;
                `SDPC_REG_ADDR_B: reg_index = 3'h2;
                `SDPC_REG_STATUS: reg_index = 3'h3;
                default: reg_index = 3'h4;
            endcase
        end
    endfunction

    // ==========================================================
    // Write channel: address and data taken in either order
    reg aw_held;
    reg w_held;
    reg [AXI_AW-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire aw_take;
    wire w_take;
    wire wr_go;
    wire [AXI_AW-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;
    assign wr_go = (aw_held || aw_take) && (w_held || w_take);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {AXI_AW{1'b0}};
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SDPC_RESP_OKAY;
            ctrl <= `SDPC_CTRL_RESET;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (reg_index(wr_addr) == 3'h0) begin
                    s_axi_bresp <= `SDPC_RESP_OKAY;
                    if (wr_strb[0]) begin
                        ctrl <= wr_data[1:0]; // see RL3
                    end
                end else if (reg_index(wr_addr) == 3'h4) begin
                    s_axi_bresp <= `SDPC_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `SDPC_RESP_OKAY;
                end
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                // Ready only while idle so one write is under way at most
                s_axi_awready <= !s_axi_bvalid && !aw_held && !aw_take
                    && !(s_axi_awvalid && s_axi_awready);
                s_axi_wready <= !s_axi_bvalid && !w_held && !w_take
                    && !(s_axi_wvalid && s_axi_wready);
            end
        end
    end

    // ==========================================================
    // Read channel
    reg [31:0] rd_word;

    always @* begin
        case (reg_index(s_axi_araddr))
            3'h0: rd_word = {30'h00000000, ctrl};
            3'h1: rd_word = {{(32-ADDR_W){1'b0}}, a_int_addr};
            3'h2: rd_word = {{(32-ADDR_W){1'b0}}, b_int_addr};
            // Status bits placed by their field positions
            3'h3: begin
                rd_word = 32'h00000000;
                rd_word[`SDPC_STAT_SEL_A] = a_selected; // see RL4
                rd_word[`SDPC_STAT_DRV_A] = a_driving;
                rd_word[`SDPC_STAT_SEL_B] = b_selected; // see RL4
                rd_word[`SDPC_STAT_DRV_B] = b_driving;
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SDPC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                if (reg_index(s_axi_araddr) == 3'h4) begin
                    s_axi_rresp <= `SDPC_RESP_SLVERR;
                end else begin
                    s_axi_rresp <= `SDPC_RESP_OKAY;
                end
            end else if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // sdpc_top

// ---- verification/sdpc_properties.sv ----
// Concurrent checks on the ports of the dual-port counter memory
`timescale 1ns/1ns
module sdpc_properties (
    input wire mclk,
    input wire reset_n,
    input wire a_chip_select_n,
    input wire a_chip_select_p,
    input wire a_read_write,
    input wire a_output_enable_n,
    input wire a_port_data_oe,
    input wire b_output_enable_n,
    input wire b_port_data_oe,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    wire a_sel = !a_chip_select_n && a_chip_select_p;

    // ==========================================================
    // Port pins
    // Two sampled cycles cover both output modes at once
    float_a_a: assert property (
        a_output_enable_n |-> !a_port_data_oe)
        else $error("port A drives with output enable off");
    float_b_a: assert property (
        b_output_enable_n |-> !b_port_data_oe)
        else $error("port B drives with output enable off");
    desel_float_a: assert property (!a_sel [*2] |=> !a_port_data_oe)
        else $error("port A drives after deselect");
    write_quiet_a: assert property ((a_sel && !a_read_write) [*2]
        |=> !a_port_data_oe)
        else $error("port A drives during writes");
    read_drive_a: assert property ((a_sel && a_read_write) [*2]
        |=> a_output_enable_n || a_port_data_oe)
        else $error("port A silent during reads");

    // ==========================================================
    // Register bus
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    b_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rresp))
        else $error("read data dropped");
endmodule // sdpc_properties

bind sdpc_top sdpc_properties i_props (.*);

// ---- verification/sdpc_host.sv ----
// Host model driving the synchronous controls of one memory port
`timescale 1ns/1ns
module sdpc_host (
    input wire mclk,
    output logic chip_select_n,
    output logic chip_select_p,
    output logic read_write,
    output logic output_enable_n,
    output logic address_strobe_n,
    output logic counter_advance_n,
    output logic counter_clear_n,
    output logic [15:0] port_address,
    output logic [7:0] port_data_in
);
    initial {chip_select_n, chip_select_p, read_write, output_enable_n,
        address_strobe_n, counter_advance_n, counter_clear_n, port_address,
        port_data_in} = {7'h5F, 24'h000000};

    // c = {oe_n, select, read, strobe_n, advance_n, clear_n}
    task op(input [5:0] c, input [15:0] a, input [7:0] d);
        @(posedge mclk);
        output_enable_n <= c[5];
        chip_select_n <= !c[4];
        chip_select_p <= c[4];
        read_write <= c[3];
        address_strobe_n <= c[2];
        counter_advance_n <= c[1];
        counter_clear_n <= c[0];
        port_address <= a;
        // Idle data lines toggle so a stale value never looks valid
        port_data_in <= c[3] ? ~port_data_in : d;
    endtask
endmodule // sdpc_host

// ---- verification/sdpc_top_test.sv ----
// Self-checking bench for the dual-port counter memory
`timescale 1ns/1ns
module sdpc_top_test;
    localparam logic [5:0] RD = 6'h1B, WR = 6'h13, WRI = 6'h15, INC = 6'h1D;
    localparam logic [5:0] HOLD = 6'h1F, DES = 6'h0F, OFF = 6'h3F;
    localparam logic [5:0] FB [8] = '{RD, INC, HOLD, DES, OFF, OFF, DES, DES};
    localparam logic [8:0] FBX [8] = '{9'h000, 9'h1A5, 9'h15A, 9'h15A,
        9'h000, 9'h000, 9'h15A, 9'h000};
    localparam logic [5:0] PA [6] = '{RD, INC, INC, DES, DES, DES};
    localparam logic [8:0] PAX [6] = '{9'h000, 9'h000, 9'h1A5, 9'h15A,
        9'h13C, 9'h000};
    localparam logic [5:0] CT [4] = '{6'h0E, 6'h0D, 6'h0B, 6'h0A};
    localparam logic [15:0] CTX [4] = '{16'h0000, 16'h0001, 16'h1234, 16'h0000};
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    wire a_chip_select_n, a_chip_select_p, a_read_write, a_output_enable_n;
    wire a_address_strobe_n, a_counter_advance_n, a_counter_clear_n;
    wire b_chip_select_n, b_chip_select_p, b_read_write, b_output_enable_n;
    wire b_address_strobe_n, b_counter_advance_n, b_counter_clear_n;
    wire [15:0] a_port_address, b_port_address;
    wire [7:0] a_port_data_in, a_port_data_out;
    wire [7:0] b_port_data_in, b_port_data_out;
    wire a_port_data_oe, b_port_data_oe;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int n_mismatch = 0;
    int compares = 0;
    // Data counts only while the port drives its pins
    wire [8:0] va = {a_port_data_oe, a_port_data_oe ? a_port_data_out : 8'h00};
    wire [8:0] vb = {b_port_data_oe, b_port_data_oe ? b_port_data_out : 8'h00};

    sdpc_top i_dut (.*);
    sdpc_host i_host_a (.mclk(mclk), .chip_select_n(a_chip_select_n),
        .chip_select_p(a_chip_select_p), .read_write(a_read_write),
        .output_enable_n(a_output_enable_n),
        .address_strobe_n(a_address_strobe_n),
        .counter_advance_n(a_counter_advance_n),
        .counter_clear_n(a_counter_clear_n), .port_address(a_port_address),
        .port_data_in(a_port_data_in));
    sdpc_host i_host_b (.mclk(mclk), .chip_select_n(b_chip_select_n),
        .chip_select_p(b_chip_select_p), .read_write(b_read_write),
        .output_enable_n(b_output_enable_n),
        .address_strobe_n(b_address_strobe_n),
        .counter_advance_n(b_counter_advance_n),
        .counter_clear_n(b_counter_clear_n), .port_address(b_port_address),
        .port_data_in(b_port_data_in));

    always #5 mclk = ~mclk;

    // ==========================================================
    // Shared tasks
    task see(input [33:0] got, input [33:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        @(posedge mclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
            s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        see(34'(s_axi_bresp), 34'(er));
    endtask

    task rd(input [7:0] a, input [33:0] exp);
        @(posedge mclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        see({s_axi_rresp, s_axi_rdata}, exp);
    endtask

    task results;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Normal run is under a hundred cycles
    initial begin
        #20000;
        n_mismatch++;
        results;
    end

    // ==========================================================
    // Scenarios; ports share one word at once only for reads, never for writes
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        rd(8'h00, 34'h000000000);
        rd(8'h10, 34'h200000000);
        i_host_a.op(WR, 16'h0005, 8'hA5);
        i_host_a.op(WRI, 16'h0000, 8'h5A);
        i_host_a.op(WRI, 16'h0000, 8'h3C);
        i_host_a.op(DES, 16'h0000, 8'h00);
        rd(8'h04, 34'h000000007);
        for (int i = 0; i < 8; i++) begin
            i_host_b.op(FB[i], 16'h0005, 8'h00);
            #1;
            if (i > 0) see(34'(vb), 34'(FBX[i]));
        end
        fork
            i_host_a.op(RD, 16'h0005, 8'h00);
            i_host_b.op(RD, 16'h0007, 8'h00);
        join
        fork
            i_host_a.op(HOLD, 16'h0000, 8'h00);
            i_host_b.op(HOLD, 16'h0000, 8'h00);
        join
        #1;
        see(34'(va), 34'h0000001A5);
        see(34'(vb), 34'h00000013C);
        rd(8'h08, 34'h000000007);
        for (int i = 0; i < 4; i++) begin
            i_host_a.op(CT[i], 16'h1234, 8'h00);
            i_host_a.op(DES, 16'h0000, 8'h00);
            rd(8'h04, {18'h00000, CTX[i]});
        end
        i_host_b.op(DES, 16'h0000, 8'h00);
        wr(8'h00, 32'h00000003, 2'h0);
        wr(8'h14, 32'h00000000, 2'h2);
        s_axi_wstrb <= 4'h0;
        wr(8'h00, 32'h00000000, 2'h0);
        rd(8'h00, 34'h000000003);
        for (int i = 0; i < 6; i++) begin
            fork
                i_host_a.op(PA[i], 16'h0005, 8'h00);
                i_host_b.op(PA[i], 16'h0005, 8'h00);
            join
            #1;
            if (i > 0) see(34'(va), 34'(PAX[i]));
            if (i > 0) see(34'(vb), 34'(PAX[i]));
        end
        results;
    end
endmodule // sdpc_top_test
